/* verilog/tpx_map.vh */
// constants of the transceiver control block
`ifndef TPX_MAP_VH
`define TPX_MAP_VH
// bit positions in the control and status words
`define TPX_CTL_LINK_EN_BIT   5
`define TPX_CTL_PORT_AUI_BIT  4
`define TPX_CTL_STP_BIT       2
`define TPX_LNK_LOOP_BIT      1
`define TPX_STS_SQE_BIT       1
`define TPX_STS_POLREV_BIT    3
`define TPX_STS_JABBER_BIT    0
`define TPX_STS_LINKFAIL_BIT  2
// timing in bit times; the clock period is 10 ns
`define TPX_CLK_NS            10
`define TPX_BIT_NS            100
`define TPX_SQE_BITS          10
`define TPX_SQUELCH_BITS      8
`define TPX_POL_PULSES        8
`define TPX_POL_FRAMES        4
`define TPX_LINK_PULSES       2
// times in microseconds
`define TPX_JAB_LIMIT_US      26000
`define TPX_UNJAB_US          500000
`define TPX_LINK_LOSS_US      100000
`define TPX_POL_RESET_US      112000
`define TPX_LINK_PERIOD_US    16000
`define TPX_PULSE_BITS        1
`define TPX_RESET_STS         8'h00
`endif

/* verilog/tpx_buf2.v */
// two-entry buffer with valid and ready on both sides
module tpx_buf2 #(
  parameter WIDTH = 1
) (
  input  wire             core_clk,
  input  wire             reset_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] spare_reg;
  reg [1:0]       count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // head sits in out_data, second word in spare_reg
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 2'd0;
      spare_reg <= {WIDTH{1'b0}};
      out_data  <= {WIDTH{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_reg == 2'd0)
            out_data <= in_data;
          else
            spare_reg <= in_data;
          count_reg <= count_reg + 2'd1;
        end
        2'b01: begin
          out_data  <= spare_reg;
          count_reg <= count_reg - 2'd1;
        end
        2'b11: begin
          if (count_reg == 2'd1)
            out_data <= in_data;
          else begin
            out_data  <= spare_reg;
            spare_reg <= in_data;
          end
        end
        default: begin
          count_reg <= count_reg;
        end
      endcase
    end
  end
endmodule

/* verilog/tpx_core.v */
// transceiver control: encode, link test, jabber, sqe, polarity, loopback
`include "tpx_map.vh"

module tpx_core #(
  parameter JAB_LIMIT_CYC  = (`TPX_JAB_LIMIT_US * 1000) / `TPX_CLK_NS,
  parameter UNJAB_CYC      = (`TPX_UNJAB_US * 1000) / `TPX_CLK_NS,
  parameter LINK_LOSS_CYC  = (`TPX_LINK_LOSS_US * 1000) / `TPX_CLK_NS,
  parameter POL_RESET_CYC  = (`TPX_POL_RESET_US * 1000) / `TPX_CLK_NS,
  parameter LINK_PER_CYC   = (`TPX_LINK_PERIOD_US * 1000) / `TPX_CLK_NS,
  parameter SQE_BITS       = `TPX_SQE_BITS,
  parameter SQUELCH_BITS   = `TPX_SQUELCH_BITS
) (
  input  wire       core_clk,
  input  wire       reset_n,
  input  wire [7:0] transceiver_control_reg,
  input  wire [7:0] link_control_reg,
  input  wire       tx_en,
  input  wire       tx_nrz,
  output wire       tx_ready,
  output reg        aui_tx_out,
  output reg        aui_tx_en,
  output reg        tp_tx_out,
  output reg        tp_tx_en,
  input  wire       tp_rx_in,
  input  wire       tp_rx_squelch,
  input  wire       tp_link_pulse,
  input  wire       tp_link_pulse_neg,
  input  wire       tp_idle_reversed,
  input  wire       aui_receive_circuit,
  input  wire       aui_rx_squelch,
  output wire       rx_valid,
  input  wire       rx_ready,
  output wire       rx_nrz,
  output reg        rx_clk,
  output reg        rx_carrier,
  output reg        collision,
  output reg        internal_collision_circuit,
  output wire [7:0] transceiver_status_reg,
  output wire       polarity_reversed_flag,
  output wire       shielded_pair_select
);
  localparam [2:0] LNK_OK   = 3'b001;
  localparam [2:0] LNK_FAIL = 3'b010;
  localparam [2:0] LNK_EXT  = 3'b100;
  localparam [1:0] JB_RUN   = 2'b01;
  localparam [1:0] JB_JAB   = 2'b10;
  localparam integer BIT_CYC = `TPX_BIT_NS / `TPX_CLK_NS;

  // pins from outside but aui_rx_squelch pass four flops; second and third must agree; aui_rx_squelch passes one flop
  wire [5:0] pin_raw = {tp_rx_in, tp_rx_squelch, tp_link_pulse,
                        tp_link_pulse_neg, tp_idle_reversed,
                        aui_receive_circuit};
  reg  [5:0] s1_reg, s2_reg, s3_reg, pin_reg;
  reg        sq_aui_reg;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 6'h00; s2_reg <= 6'h00; s3_reg <= 6'h00;
      pin_reg <= 6'h00; sq_aui_reg <= 1'b0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));
      sq_aui_reg <= aui_rx_squelch;
    end
  end
  wire tpi_d   = pin_reg[5];
  wire tpi_sq  = pin_reg[4];
  wire lp_pos  = pin_reg[3];
  wire lp_neg  = pin_reg[2];
  wire idl_rev = pin_reg[1];
  wire aui_d   = pin_reg[0];
  reg  [3:0] lp_d_reg;
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n) lp_d_reg <= 4'h0;
    else lp_d_reg <= {lp_pos, lp_neg, idl_rev, tpi_sq};
  wire lp_pos_ev = lp_pos & ~lp_d_reg[3];
  wire lp_neg_ev = lp_neg & ~lp_d_reg[2];
  wire frame_end = ~tpi_sq & lp_d_reg[0];

  wire port_aui  = transceiver_control_reg[`TPX_CTL_PORT_AUI_BIT];
  wire link_off  = transceiver_control_reg[`TPX_CTL_LINK_EN_BIT];
  wire loop_control = link_control_reg[`TPX_LNK_LOOP_BIT];
  assign shielded_pair_select = transceiver_control_reg[`TPX_CTL_STP_BIT];

  // bit timer: one tick per bit, half tick for manchester halves
  reg [3:0] bt_reg;
  wire bit_tick  = (bt_reg == BIT_CYC - 1);
  wire half_tick = (bt_reg == BIT_CYC / 2 - 1);
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n) bt_reg <= 4'h0;
    else bt_reg <= bit_tick ? 4'h0 : bt_reg + 4'h1;

  // transmit word through two-entry buffer, one word per bit time
  wire buf_valid, buf_data;
  tpx_buf2 #(.WIDTH(1)) u_txbuf (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .in_valid (tx_en),
    .in_ready (tx_ready),
    .in_data  (tx_nrz),
    .out_valid(buf_valid),
    .out_ready(bit_tick),
    .out_data (buf_data)
  );

  reg [2:0] lnk_reg;
  reg [1:0] jb_reg;
  reg       tx_act_reg, enc_bit_reg;
  wire jabber   = jb_reg[1];
  wire linkfail = ~link_off & ~port_aui & ~lnk_reg[0];
  wire tx_block = jabber | linkfail;

  // encoder: first half inverted data, second half data
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_act_reg <= 1'b0; enc_bit_reg <= 1'b0;
    end else if (bit_tick) begin
      tx_act_reg  <= buf_valid;
      enc_bit_reg <= buf_data;
    end
  end
  wire enc_line = tx_act_reg & (enc_bit_reg ^ (bt_reg < BIT_CYC / 2));

  // link pulse generator while idle on twisted pair
  reg [23:0] lp_tmr_reg;
  wire lp_fire = (lp_tmr_reg == LINK_PER_CYC - 1);
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n) lp_tmr_reg <= 24'h00_0000;
    else if (lp_fire | tx_act_reg) lp_tmr_reg <= 24'h00_0000;
    else lp_tmr_reg <= lp_tmr_reg + 24'h00_0001;
  // no pulses in jabber: the line stays quiet until unjab
  wire lp_out = lp_fire & ~link_off & ~port_aui & ~jabber;

  // output drivers; loopback blocks nothing on the line
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aui_tx_out <= 1'b0; aui_tx_en <= 1'b0;
      tp_tx_out <= 1'b0; tp_tx_en <= 1'b0;
    end else begin
      aui_tx_out <= enc_line;
      aui_tx_en  <= port_aui & tx_act_reg & ~jabber;
      tp_tx_out  <= enc_line | lp_out;
      tp_tx_en   <= ~port_aui & ((tx_act_reg & ~tx_block) | lp_out);
    end
  end

  // jabber watchdog and unjab timer
  reg [25:0] jb_cnt_reg;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      jb_reg <= JB_RUN; jb_cnt_reg <= 26'h000_0000;
    end else begin
      case (jb_reg)
        JB_RUN: begin
          if (!tx_act_reg) jb_cnt_reg <= 26'h000_0000;
          else if (jb_cnt_reg == JAB_LIMIT_CYC - 1) begin
            jb_reg <= JB_JAB; jb_cnt_reg <= 26'h000_0000;
          end else jb_cnt_reg <= jb_cnt_reg + 26'h000_0001;
        end
        JB_JAB: begin
          if (tx_en) jb_cnt_reg <= 26'h000_0000;
          else if (jb_cnt_reg == UNJAB_CYC - 1) begin
            jb_reg <= JB_RUN; jb_cnt_reg <= 26'h000_0000;
          end else jb_cnt_reg <= jb_cnt_reg + 26'h000_0001;
        end
        default: jb_reg <= JB_RUN;
      endcase
    end
  end

  // sqe after a clean twisted-pair transmit
  reg [4:0] sqe_cnt_reg;
  reg       tx_prev_reg;
  reg       sqe_on_reg;
  // status shows sqe alone; collisions only share the line
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sqe_cnt_reg <= 5'h00; tx_prev_reg <= 1'b0;
      internal_collision_circuit <= 1'b0;
      sqe_on_reg <= 1'b0;
    end else begin
      tx_prev_reg <= tx_act_reg;
      sqe_on_reg  <= (sqe_cnt_reg != 5'h00);
      if (tx_prev_reg & ~tx_act_reg & ~port_aui & ~tx_block & ~collision)
        sqe_cnt_reg <= SQE_BITS[4:0];
      else if (bit_tick && sqe_cnt_reg != 5'h00)
        sqe_cnt_reg <= sqe_cnt_reg - 5'h01;
      internal_collision_circuit <= (sqe_cnt_reg != 5'h00) |
                                    (collision & ~loop_control);
    end
  end

  // link integrity: fail on silence, recover on packet or two pulses
  reg [23:0] lk_tmr_reg;
  reg [1:0]  lk_pls_reg;
  reg        pol_inv_reg;
  wire rx_seen = lp_pos_ev | lp_neg_ev | tpi_sq;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lnk_reg <= LNK_OK; lk_tmr_reg <= 24'h00_0000; lk_pls_reg <= 2'b00;
    end else if (link_off) begin
      lnk_reg <= LNK_OK; lk_tmr_reg <= 24'h00_0000;
    end else begin
      case (lnk_reg)
        LNK_OK: begin
          if (rx_seen) lk_tmr_reg <= 24'h00_0000;
          else if (lk_tmr_reg == LINK_LOSS_CYC - 1) begin
            lnk_reg <= LNK_FAIL; lk_tmr_reg <= 24'h00_0000;
            lk_pls_reg <= 2'b00;
          end else lk_tmr_reg <= lk_tmr_reg + 24'h00_0001;
        end
        LNK_FAIL, LNK_EXT: begin
          if (frame_end ||
              ((lp_pos_ev | lp_neg_ev) &&
               lk_pls_reg == `TPX_LINK_PULSES - 1)) begin
            lnk_reg <= LNK_OK; lk_tmr_reg <= 24'h00_0000;
          end else begin
            if (lp_pos_ev | lp_neg_ev) lk_pls_reg <= lk_pls_reg + 2'b01;
            if (rx_seen) lk_tmr_reg <= 24'h00_0000;
            else if (lk_tmr_reg == POL_RESET_CYC - 1) lnk_reg <= LNK_EXT;
            else lk_tmr_reg <= lk_tmr_reg + 24'h00_0001;
          end
        end
        default: lnk_reg <= LNK_OK;
      endcase
    end
  end

  // polarity detect and correct; frame check always on, pulse check only with link test on
  reg [3:0] pol_lp_reg;
  reg [2:0] pol_fr_reg;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pol_inv_reg <= 1'b0; pol_lp_reg <= 4'h0; pol_fr_reg <= 3'h0;
    end else if (lnk_reg == LNK_FAIL && !rx_seen &&
                 lk_tmr_reg == POL_RESET_CYC - 1) begin
      pol_inv_reg <= 1'b0; pol_lp_reg <= 4'h0; pol_fr_reg <= 3'h0;
    end else if ((!link_off && lp_neg_ev &&
                  pol_lp_reg == `TPX_POL_PULSES - 1) ||
                 (frame_end && idl_rev &&
                  pol_fr_reg == `TPX_POL_FRAMES - 1)) begin
      pol_inv_reg <= ~pol_inv_reg;
      pol_lp_reg  <= 4'h0;
      pol_fr_reg  <= 3'h0;
    end else begin
      if (link_off) pol_lp_reg <= 4'h0;
      else if (lp_pos_ev) pol_lp_reg <= 4'h0;
      else if (lp_neg_ev) pol_lp_reg <= pol_lp_reg + 4'h1;
      if (frame_end && idl_rev) pol_fr_reg <= pol_fr_reg + 3'h1;
    end
  end
  // opposite/reversed inputs are counted raw from the pins, not relative to the current correction
  assign polarity_reversed_flag = pol_inv_reg;

  // squelch to idle after quiet bit times
  reg [3:0] quiet_reg;
  wire      sq_in = port_aui ? sq_aui_reg : tpi_sq;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_reg <= 4'h0; rx_carrier <= 1'b0;
    end else if (sq_in) begin
      quiet_reg <= 4'h0; rx_carrier <= 1'b1;
    end else if (bit_tick && rx_carrier) begin
      if (quiet_reg == SQUELCH_BITS - 1) rx_carrier <= 1'b0;
      else quiet_reg <= quiet_reg + 4'h1;
    end
  end

  // collision and loopback source selection
  wire tp_act   = ~port_aui & tx_act_reg & ~tx_block;
  wire col_now  = tp_act & rx_carrier & ~port_aui;
  wire norm_lb  = tp_act & ~tx_block & (~col_now | loop_control);
  wire aui_lb   = port_aui & loop_control & tx_act_reg & ~jabber;
  wire use_loop = norm_lb | aui_lb;
  wire line_in  = port_aui ? aui_d : (tpi_d ^ pol_inv_reg);

  always @(posedge core_clk or negedge reset_n)
    if (!reset_n) collision <= 1'b0;
    else collision <= col_now & ~loop_control;

  // decoder samples second half of each bit cell
  reg dec_bit_reg, dec_vld_reg;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dec_bit_reg <= 1'b0; dec_vld_reg <= 1'b0; rx_clk <= 1'b0;
    end else begin
      dec_vld_reg <= 1'b0;
      if (half_tick) rx_clk <= 1'b0;
      if (bit_tick) begin
        rx_clk <= use_loop | rx_carrier;
        dec_bit_reg <= use_loop ? enc_line : line_in;
        dec_vld_reg <= use_loop | rx_carrier;
      end
    end
  end

  // receive words leave through a second two-entry buffer
  tpx_buf2 #(.WIDTH(1)) u_rxbuf (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .in_valid (dec_vld_reg),
    .in_ready (),
    .in_data  (dec_bit_reg),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data (rx_nrz)
  );

  assign transceiver_status_reg = {4'h0, pol_inv_reg, linkfail,
                                   sqe_on_reg,
                                   jabber};
endmodule

/* tb/tpx_props.sv */
// assertions watching the transceiver control ports
module tpx_props #(
  parameter UNJAB_CYC = 600
) (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic [7:0] transceiver_control_reg,
  input wire logic [7:0] link_control_reg,
  input wire logic       tx_en,
  input wire logic       tp_tx_en,
  input wire logic       aui_tx_en,
  input wire logic       collision,
  input wire logic       internal_collision_circuit,
  input wire logic [7:0] transceiver_status_reg,
  input wire logic       polarity_reversed_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] idle_cnt_reg;
  logic [15:0] sqe_cnt_reg;
  wire  [7:0]  sts = transceiver_status_reg;
  wire  [7:0]  ctl = transceiver_control_reg;
  // idle run of transmit data and length of the sqe pulse
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt_reg <= 32'h0000_0000;
      sqe_cnt_reg  <= 16'h0000;
    end else begin
      idle_cnt_reg <= tx_en ? 32'h0000_0000 : idle_cnt_reg + 32'h0000_0001;
      sqe_cnt_reg  <= sts[1] ? sqe_cnt_reg + 16'h0001 : 16'h0000;
    end
  end
  // sqe bit only while the sqe signal is driven
  a_sqe_status_mirror: assert property (
    sts[1] |-> internal_collision_circuit) else $error("sqe bit alone");
  a_sqe_pulse_length: assert property (
    $fell(sts[1]) |-> sqe_cnt_reg >= 16'h0032 && sqe_cnt_reg <= 16'h0096)
    else $error("sqe pulse length off");
  a_sqe_tp_only: assert property (
    $rose(sts[1]) |-> !ctl[4]) else $error("sqe on aui port");
  // jabber keeps both lines quiet, and leaves only after long idle
  a_jabber_blocks_tx: assert property (
    sts[0] && $past(sts[0]) |-> !tp_tx_en && !aui_tx_en)
    else $error("line driven in jabber");
  a_unjab_idle_wait: assert property (
    $fell(sts[0]) |-> idle_cnt_reg >= UNJAB_CYC - 2)
    else $error("jabber left too early");
  a_polarity_status: assert property (
    sts[3] == polarity_reversed_flag) else $error("polarity bit differs");
  // the port select steers the encoded stream to one line only
  a_port_one_line: assert property (
    !(tp_tx_en && aui_tx_en)) else $error("both lines driven");
  a_aui_quiet_tp: assert property (
    ctl[4] && $past(ctl[4], 3) |-> !tp_tx_en) else $error("tp driven on aui");
  a_loop_beats_col: assert property (
    link_control_reg[1] && $past(link_control_reg[1], 3) |-> !collision)
    else $error("collision under loop control");
  c_unjab: cover property ($fell(sts[0]));
  c_polrev: cover property ($rose(polarity_reversed_flag));
  c_col: cover property ($rose(collision));
endmodule

bind tpx_core tpx_props #(.UNJAB_CYC(UNJAB_CYC)) u_props (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .transceiver_control_reg(transceiver_control_reg),
  .link_control_reg(link_control_reg),
  .tx_en(tx_en),
  .tp_tx_en(tp_tx_en),
  .aui_tx_en(aui_tx_en),
  .collision(collision),
  .internal_collision_circuit(internal_collision_circuit),
  .transceiver_status_reg(transceiver_status_reg),
  .polarity_reversed_flag(polarity_reversed_flag)
);

/* tb/tpx_far_model.sv */
// far-side model: remote node sending link pulses and frames
module tpx_far_model (
  input  wire logic core_clk,
  output logic      tp_rx_in,
  output logic      tp_rx_squelch,
  output logic      tp_link_pulse,
  output logic      tp_link_pulse_neg,
  output logic      tp_idle_reversed,
  output logic      aui_receive_circuit,
  output logic      aui_rx_squelch
);
  timeunit 1ns;
  timeprecision 1ps;
  logic frame_level;
  initial begin
    tp_rx_in = 1'b0;
    tp_rx_squelch = 1'b0;
    tp_link_pulse = 1'b0;
    tp_link_pulse_neg = 1'b0;
    tp_idle_reversed = 1'b0;
    aui_receive_circuit = 1'b0;
    aui_rx_squelch = 1'b0;
    frame_level = 1'b0;
  end
  // released data lines wander so a stale level never reads as data
  always @(posedge core_clk) begin
    tp_rx_in <= tp_rx_squelch ? frame_level : ~tp_rx_in;
    aui_receive_circuit <= ~aui_receive_circuit;
  end
  // link pulses of either polarity, each followed by a quiet gap
  task automatic pulses(input int n, input logic neg);
    for (int i = 0; i < n; i++) begin
      tp_link_pulse <= ~neg;
      tp_link_pulse_neg <= neg;
      repeat (4) @(posedge core_clk);
      tp_link_pulse <= 1'b0;
      tp_link_pulse_neg <= 1'b0;
      repeat (100) @(posedge core_clk);
    end
  endtask
  // frames of alternating cells; rev marks a reversed start of idle
  task automatic frames(input int n, input logic rev);
    for (int i = 0; i < n; i++) begin
      tp_rx_squelch <= 1'b1;
      for (int c = 0; c < 40; c++) begin
        frame_level <= c[0];
        repeat (5) @(posedge core_clk);
      end
      tp_rx_squelch <= 1'b0;
      tp_idle_reversed <= rev;
      repeat (4) @(posedge core_clk);
      tp_idle_reversed <= 1'b0;
      repeat (60) @(posedge core_clk);
    end
  endtask
endmodule

/* tb/tb_tp_aui_transceiver_control.sv */
// self-checking bench for the transceiver control block
module tb_tp_aui_transceiver_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UNJAB = 600;
  localparam int LOSS  = 3000;
  localparam int POLR  = 400;
  localparam int LPER  = 300;
  logic        core_clk, reset_n, tx_en, tx_nrz, rx_ready;
  logic [7:0]  ctl, lnk;
  logic [15:0] word;
  logic        rxq[$];
  wire  [7:0]  sts;
  wire         tx_ready, aui_tx_en, tp_tx_en, rx_valid, rx_nrz, col, pol;
  wire         rx_in, rx_sq, lp, lpn, idle_rev, aui_in, aui_sq;
  int          failures, total_checks, tp_cnt, aui_cnt, col_cnt, full_cnt, n;

  tpx_core #(.JAB_LIMIT_CYC(1500), .UNJAB_CYC(UNJAB), .LINK_LOSS_CYC(LOSS),
    .POL_RESET_CYC(POLR), .LINK_PER_CYC(LPER)) DUT (
    .core_clk(core_clk), .reset_n(reset_n),
    .transceiver_control_reg(ctl), .link_control_reg(lnk),
    .tx_en(tx_en), .tx_nrz(tx_nrz), .tx_ready(tx_ready),
    .aui_tx_out(), .aui_tx_en(aui_tx_en), .tp_tx_out(), .tp_tx_en(tp_tx_en),
    .tp_rx_in(rx_in), .tp_rx_squelch(rx_sq), .tp_link_pulse(lp),
    .tp_link_pulse_neg(lpn), .tp_idle_reversed(idle_rev),
    .aui_receive_circuit(aui_in), .aui_rx_squelch(aui_sq),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_nrz(rx_nrz), .rx_clk(),
    .rx_carrier(), .collision(col), .internal_collision_circuit(),
    .transceiver_status_reg(sts), .polarity_reversed_flag(pol),
    .shielded_pair_select());

  tpx_far_model u_far (.core_clk(core_clk), .tp_rx_in(rx_in),
    .tp_rx_squelch(rx_sq), .tp_link_pulse(lp), .tp_link_pulse_neg(lpn),
    .tp_idle_reversed(idle_rev), .aui_receive_circuit(aui_in),
    .aui_rx_squelch(aui_sq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // line activity tallies and capture of received bits
  always @(posedge core_clk) begin
    tp_cnt = tp_cnt + int'(tp_tx_en === 1'b1);
    aui_cnt = aui_cnt + int'(aui_tx_en === 1'b1);
    col_cnt = col_cnt + int'(col === 1'b1);
    full_cnt = full_cnt + int'(tx_ready === 1'b0);
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_nrz);
  end

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    tick(5);
    reset_n <= 1'b1;
    tick(1);
  endtask
  // request held until tx_ready is seen high at an edge
  task automatic send_bits(input logic [15:0] d, input int nb);
    for (int i = 0; i < nb; i++) begin
      tx_en <= 1'b1;
      tx_nrz <= d[i];
      do @(posedge core_clk); while (tx_ready !== 1'b1);
    end
    tx_en <= 1'b0;
  endtask
  task automatic wait_sts(input int b, input logic v, input int lim);
    n = 0;
    while (sts[b] !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic expect_rx(input logic [15:0] exp, input int nb);
    word = 16'h0000;
    foreach (rxq[i]) if (i < 16) word[i] = rxq[i];
    check(word, exp);
    check(16'(rxq.size()), 16'(nb));
  endtask
  task automatic collide();
    col_cnt = 0;
    fork
      send_bits(16'hFFFF, 16);
      u_far.frames(1, 1'b0);
    join
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    failures++;
    final_report();
  end

  initial begin
    ctl = 8'h20;
    lnk = 8'h00;
    tx_en = 1'b0;
    tx_nrz = 1'b0;
    rx_ready = 1'b1;
    reset_n = 1'b0;
    failures = 0;
    total_checks = 0;
    do_reset();
    check(sts, 16'h0000);
    check(tx_ready, 1'b1);
    done("reset");
    // twisted pair loopback with a brief receiver stall
    tp_cnt = 0;
    aui_cnt = 0;
    fork
      send_bits(16'hA5C3, 16);
      begin tick(100); rx_ready <= 1'b0; tick(15); rx_ready <= 1'b1; end
    join
    wait_sts(1, 1'b1, 400);
    check(sts[1], 1'b1);
    wait_sts(1, 1'b0, 400);
    check(n >= 50 && n <= 150, 1'b1);
    tick(50);
    expect_rx(16'hA5C3, 16);
    check(tp_cnt > 0 && aui_cnt == 0, 1'b1);
    done("tp loopback");
    // aui port without and with loop control
    ctl <= 8'h30;
    tick(2);
    rxq.delete();
    tp_cnt = 0;
    send_bits(16'h00FF, 8);
    tick(80);
    check(aui_cnt > 0 && tp_cnt == 0, 1'b1);
    expect_rx(16'h0000, 0);
    lnk <= 8'h02;
    tick(2);
    send_bits(16'h0096, 8);
    tick(80);
    expect_rx(16'h0096, 8);
    done("aui");
    // transmit held on until the watchdog cuts it, then idle
    ctl <= 8'h20;
    lnk <= 8'h00;
    full_cnt = 0;
    tx_en <= 1'b1;
    tx_nrz <= 1'b1;
    wait_sts(0, 1'b1, 1800);
    tick(3);
    check(sts[0], 1'b1);
    check(tp_tx_en, 1'b0);
    check(full_cnt > 0, 1'b1);
    tx_en <= 1'b0;
    tick(1);
    wait_sts(0, 1'b0, UNJAB + 100);
    check(n >= UNJAB - 3 && n <= UNJAB + 10, 1'b1);
    done("jabber");
    // link test on: idle pulses, polarity, link fail and recovery
    ctl <= 8'h00;
    tp_cnt = 0;
    tick(LPER + 50);
    check(tp_cnt > 0, 1'b1);
    u_far.pulses(7, 1'b1);
    check(pol, 1'b0);
    u_far.pulses(1, 1'b1);
    check(pol, 1'b1);
    wait_sts(2, 1'b1, LOSS + 300);
    check(sts[2], 1'b1);
    rxq.delete();
    send_bits(16'h00AA, 8);
    tick(40);
    check(16'(rxq.size()), 16'h0000);
    tick(POLR);
    check(pol, 1'b0);
    u_far.pulses(2, 1'b0);
    check(sts[2], 1'b0);
    done("link");
    // link test off: reversed start of idle on received frames
    ctl <= 8'h20;
    u_far.frames(3, 1'b1);
    check(pol, 1'b0);
    u_far.frames(1, 1'b1);
    check(pol, 1'b1);
    do_reset();
    check(pol, 1'b0);
    done("frame polarity");
    // collision, then loop control holding it off
    collide();
    check(col_cnt > 0, 1'b1);
    lnk <= 8'h02;
    tick(5);
    collide();
    check(col_cnt == 0, 1'b1);
    done("collision");
    final_report();
  end
endmodule
